//--- hdl/timer_module_one.sv
// Three-timer general purpose module: core timer plus two auxiliary timers
`timescale 1ns/1ps
`include "timer_module_one_map.svh"

module timer_module_one #(
   parameter int CNT_W = `COUNT_WIDTH
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // External pins, one input and one direction pin per timer
   input wire logic [2:0] timer_input_pin,
   input wire logic [2:0] timer_direction_pin,
   // Per-timer configuration
   input timer_module_one_pkg::timer_mode_t mode [3],
   input wire logic [2:0] run,
   input wire logic [2:0][2:0] presc_sel,
   input timer_module_one_pkg::edge_sel_t edge_sel [3],
   input wire logic [2:0] gate_level,
   input wire logic [2:0] count_down,
   input wire logic [2:0] dir_pin_enable,
   // Auxiliary timer roles (core slot ignored)
   input timer_module_one_pkg::aux_func_t aux_func [3],
   input wire logic [2:0] aux_src_latch,
   input wire logic [2:0] reload_from_latch,
   // Software load of timer values
   input wire logic [2:0] load_strobe,
   input wire logic [2:0][CNT_W-1:0] load_value,
   // Interrupt request flag clear
   input wire logic [2:0] irq_clear,
   // Core latch output enable
   input wire logic toggle_out_enable,
   // Status
   output logic [2:0][CNT_W-1:0] count_value,
   output logic [2:0] irq_flag,
   output logic core_toggle_latch,
   output logic toggle_output_pin
);

   localparam int CORE = `SLOT_CORE;

   logic [`PRESC_WIDTH-1:0] presc;
   logic [2:0] in_lvl, in_rise, in_fall, dir_lvl, dir_rise, dir_fall;
   logic [2:0] tick, step, up, wrap, pin_edge, latch_edge, hold;
   logic [2:0] capture_hit, reload_hit;
   logic [2:0][CNT_W-1:0] next_count;
   logic latch_last;
   logic next_latch;

   // Shared free-running prescaler; each timer taps its own span
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         presc <= `PRESC_RESET;
      end else begin
         presc <= presc + 1'b1;
      end
   end

   // Core latch transitions, used for chaining and reload triggers
   wire latch_rise = core_toggle_latch & ~latch_last;
   wire latch_fall = ~core_toggle_latch & latch_last;

   genvar i;
   generate
      for (i = 0; i < `NUM_TIMERS; i++) begin : g_timer
         // Input and direction pins pass through a synchroniser
         pin_conditioner u_in (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin(timer_input_pin[i]),
            .level(in_lvl[i]),
            .rise(in_rise[i]),
            .fall(in_fall[i])
         );
         pin_conditioner u_dir (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin(timer_direction_pin[i]),
            .level(dir_lvl[i]),
            .rise(dir_rise[i]),
            .fall(dir_fall[i])
         );

         // Prescaler tap: all low bits of the span set
         wire [10:0] span = `PRESC_BASE << presc_sel[i];
         wire [`PRESC_WIDTH-1:0] mask = `PRESC_WIDTH'(span - 11'h001);
         assign tick[i] = (presc & mask) == mask;

         // Edge selection on the pin and on the core latch
         wire sel_r = edge_sel[i] == timer_module_one_pkg::EDGE_RISE;
         wire sel_f = edge_sel[i] == timer_module_one_pkg::EDGE_FALL;
         wire sel_b = edge_sel[i] == timer_module_one_pkg::EDGE_BOTH;
         assign pin_edge[i] = ((sel_r | sel_b) & in_rise[i]) | ((sel_f | sel_b) & in_fall[i]);
         assign latch_edge[i] = ((sel_r | sel_b) & latch_rise) | ((sel_f | sel_b) & latch_fall);

         // Auxiliary count source: own pin or core latch
         wire src_edge = (i != CORE && aux_src_latch[i]) ? latch_edge[i] : pin_edge[i];

         // Quadrature: only one phase may change per cycle
         wire a_chg = in_rise[i] | in_fall[i];
         wire b_chg = dir_rise[i] | dir_fall[i];
         wire q_step = a_chg ^ b_chg;
         wire q_up = a_chg ? (in_lvl[i] != dir_lvl[i]) : (in_lvl[i] == dir_lvl[i]);

         // Mode decode of the count enable
         wire is_timer = mode[i] == timer_module_one_pkg::MODE_TIMER;
         wire is_gated = mode[i] == timer_module_one_pkg::MODE_GATED;
         wire is_counter = mode[i] == timer_module_one_pkg::MODE_COUNTER;
         wire gate_open = in_lvl[i] == gate_level[i];
         wire mode_step = is_timer ? tick[i] :
                          is_gated ? (tick[i] & gate_open) :
                          is_counter ? src_edge : q_step;
         assign hold[i] = (i != CORE) && aux_func[i] != timer_module_one_pkg::AUX_COUNT;
         assign step[i] = run[i] & mode_step & ~hold[i];

         // Direction: software bit, flipped by pin level when enabled
         assign up[i] = (mode[i] == timer_module_one_pkg::MODE_INCREMENTAL) ? q_up :
                        ~(count_down[i] ^ (dir_pin_enable[i] & dir_lvl[i]));
         wire at_edge = up[i] ? (count_value[i] == '1) : (count_value[i] == '0);
         assign wrap[i] = step[i] & at_edge;
         wire [CNT_W-1:0] stepped = up[i] ? CNT_W'(count_value[i] + 1'b1) : CNT_W'(count_value[i] - 1'b1);

         // Capture and reload triggers of an auxiliary timer
         wire trig = (i != CORE && reload_from_latch[i]) ? latch_edge[i] : pin_edge[i];
         assign capture_hit[i] = (i != CORE) && aux_func[i] == timer_module_one_pkg::AUX_CAPTURE && pin_edge[i];
         assign reload_hit[i] = (i != CORE) && aux_func[i] == timer_module_one_pkg::AUX_RELOAD && trig;

         // Next value; core takes reloads, auxiliaries take captures
         if (i == CORE) begin : g_core
            wire [CNT_W-1:0] reload_val = reload_hit[`SLOT_AUX_LOW] ? count_value[`SLOT_AUX_LOW] :
                                          count_value[`SLOT_AUX_HIGH];
            assign next_count[i] = load_strobe[i] ? load_value[i] :
                                   (|reload_hit) ? reload_val :
                                   step[i] ? stepped : count_value[i];
         end else begin : g_aux
            assign next_count[i] = load_strobe[i] ? load_value[i] :
                                   capture_hit[i] ? count_value[CORE] :
                                   step[i] ? stepped : count_value[i];
         end

         // Count register and request flag; a wrap beats a clear
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               count_value[i] <= `COUNT_RESET;
               irq_flag[i] <= 1'b0;
            end else begin
               count_value[i] <= next_count[i];
               irq_flag[i] <= wrap[i] | (irq_flag[i] & ~irq_clear[i]);
            end
         end
      end
   endgenerate

   // Toggle latch flips on every core wrap
   assign next_latch = core_toggle_latch ^ wrap[CORE];

   // Latch, its history and the gated output pin, all registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_toggle_latch <= `LATCH_RESET;
         latch_last <= `LATCH_RESET;
         toggle_output_pin <= 1'b0;
      end else begin
         core_toggle_latch <= next_latch;
         latch_last <= core_toggle_latch;
         toggle_output_pin <= next_latch & toggle_out_enable;
      end
   end

   // Checks on the counting behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_core_wrap_up: assert property (
      (wrap[CORE] && up[CORE] && !load_strobe[CORE] && !(|reload_hit))
      |=> (count_value[CORE] == '0) && irq_flag[CORE])
      else $error("core up wrap did not reach zero with flag");
   a_core_wrap_down: assert property (
      (wrap[CORE] && !up[CORE] && !load_strobe[CORE] && !(|reload_hit))
      |=> (count_value[CORE] == '1) && irq_flag[CORE])
      else $error("core down wrap did not reach all ones");
   a_latch_toggles: assert property (
      wrap[CORE] |=> core_toggle_latch != $past(core_toggle_latch))
      else $error("toggle latch missed a wrap");
   a_pin_follows: assert property (
      (toggle_out_enable && $past(toggle_out_enable)) |-> toggle_output_pin == core_toggle_latch)
      else $error("output pin does not follow latch");
   a_aux_held: assert property (
      (hold[0] && !load_strobe[0] && !capture_hit[0]) |=> $stable(count_value[0]))
      else $error("held auxiliary timer changed");
   a_capture_copy: assert property (
      (capture_hit[0] && !load_strobe[0]) |=> count_value[0] == $past(count_value[CORE]))
      else $error("capture did not copy core value");
   a_reload_load: assert property (
      (reload_hit[0] && !load_strobe[CORE]) |=> count_value[CORE] == $past(count_value[0]))
      else $error("reload did not load core");
   a_presc_rate: assert property (
      (tick[CORE] && presc_sel[CORE] == 3'h0 && $past(presc_sel[CORE]) == 3'h0)
      |=> !tick[CORE] [*7] ##1 tick[CORE])
      else $error("divide by eight tick spacing wrong");
   a_gate_closed: assert property (
      (run[0] && mode[0] == timer_module_one_pkg::MODE_GATED && in_lvl[0] != gate_level[0]
       && !load_strobe[0] && !capture_hit[0]) |=> $stable(count_value[0]))
      else $error("gated timer counted with gate closed");
   a_count_up: assert property (
      (step[CORE] && up[CORE] && !wrap[CORE] && !load_strobe[CORE] && !(|reload_hit))
      |=> count_value[CORE] == $past(count_value[CORE]) + 1'b1)
      else $error("core failed to count up by one");

   c_core_wrap: cover property (wrap[CORE]);
   c_capture: cover property (capture_hit[0] || capture_hit[2]);
   c_alternate: cover property (reload_hit[0] ##[1:200] reload_hit[2]);
   c_quadrature: cover property (step[CORE] && mode[CORE] == timer_module_one_pkg::MODE_INCREMENTAL);

endmodule

//--- shared/timer_module_one_map.svh
// Constants for the first general purpose timer module
`ifndef TIMER_MODULE_ONE_MAP_SVH
`define TIMER_MODULE_ONE_MAP_SVH

// Timer width and slot indices
`define COUNT_WIDTH 16
`define NUM_TIMERS 3
`define SLOT_AUX_LOW 0
`define SLOT_CORE 1
`define SLOT_AUX_HIGH 2

// Prescaler: factor is PRESC_BASE << select, 8 up to 1024
`define PRESC_WIDTH 10
`define PRESC_BASE 11'h008
`define PRESC_RESET 10'h000

// Reset values
`define COUNT_RESET 16'h0000
`define LATCH_RESET 1'b0

`endif

//--- shared/timer_module_one_pkg.sv
// Types shared by the timer module and its testbench
package timer_module_one_pkg;

   // Basic operating mode of one timer
   typedef enum logic [1:0] {
      MODE_TIMER,
      MODE_GATED,
      MODE_COUNTER,
      MODE_INCREMENTAL
   } timer_mode_t;

   // Which transition of an input is taken
   typedef enum logic [1:0] {
      EDGE_NONE,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_sel_t;

   // Role of an auxiliary timer
   typedef enum logic [1:0] {
      AUX_COUNT,
      AUX_CAPTURE,
      AUX_RELOAD,
      AUX_SPARE
   } aux_func_t;

endpackage

//--- hdl/pin_conditioner.sv
// Two-stage synchroniser with edge detection for one timer pin
`timescale 1ns/1ps

module pin_conditioner (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Raw pin
   input wire logic pin,
   // Conditioned level and edges
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta;
   logic last;

   // First stage feeds only the second; edges compare stages two and three
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         level <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= pin;
         level <= meta;
         last <= level;
      end
   end

   // Edge pulses last one cycle
   assign rise = level & ~last;
   assign fall = ~level & last;

endmodule

//--- tb/pin_source.sv
// Model of the external gate, event and encoder pins
`timescale 1ns/1ps

module pin_source (
   // Clock
   input wire logic sys_clk,
   // Pins toward the timers
   output logic [2:0] in_pin,
   output logic [2:0] dir_pin
);
   // Encoder and gate lines hold their level between events
   initial begin
      in_pin = 3'h0;
      dir_pin = 3'h0;
   end

   // Two cycles at each level so the synchroniser sees both edges
   task automatic pulse(input int i);
      @(negedge sys_clk);
      in_pin[i] = 1'b1;
      repeat (2) @(negedge sys_clk);
      in_pin[i] = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // One quadrature step; never both phases at once
   task automatic quad(input int i, input logic fwd);
      @(negedge sys_clk);
      if (fwd ^ in_pin[i] ^ dir_pin[i]) begin
         in_pin[i] = ~in_pin[i];
      end else begin
         dir_pin[i] = ~dir_pin[i];
      end
      repeat (3) @(negedge sys_clk);
   endtask
endmodule

//--- tb/timer_module_one_tb_top.sv
// Self-checking bench for the three-timer module
`timescale 1ns/1ps

module timer_module_one_tb_top;
   typedef struct {logic [2:0] sel; logic down; int period;} row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic [2:0] timer_input_pin;
   wire logic [2:0] timer_direction_pin;
   timer_module_one_pkg::timer_mode_t mode [3];
   timer_module_one_pkg::edge_sel_t edge_sel [3];
   timer_module_one_pkg::aux_func_t aux_func [3];
   logic [2:0] run, gate_level, count_down, dir_pin_enable, aux_src_latch;
   logic [2:0] reload_from_latch, load_strobe, irq_clear, irq_flag;
   logic [2:0][2:0] presc_sel;
   logic [2:0][15:0] load_value, count_value;
   logic toggle_out_enable, core_toggle_latch, toggle_output_pin;
   int miscompares = 0;
   int checked = 0;
   int n;
   logic [15:0] old;
   row_t rows [8] = '{'{3'h0, 1'b0, 8}, '{3'h1, 1'b1, 16}, '{3'h2, 1'b0, 32}, '{3'h3, 1'b1, 64},
                      '{3'h4, 1'b0, 128}, '{3'h5, 1'b1, 256}, '{3'h6, 1'b0, 512}, '{3'h7, 1'b1, 1024}};

   // 100 ns period
   always #50 sys_clk = ~sys_clk;

   timer_module_one dut (.sys_clk, .rst_n, .timer_input_pin, .timer_direction_pin, .mode, .run,
      .presc_sel, .edge_sel, .gate_level, .count_down, .dir_pin_enable, .aux_func, .aux_src_latch,
      .reload_from_latch, .load_strobe, .load_value, .irq_clear, .toggle_out_enable, .count_value,
      .irq_flag, .core_toggle_latch, .toggle_output_pin);

   pin_source src (.sys_clk(sys_clk), .in_pin(timer_input_pin), .dir_pin(timer_direction_pin));

   // Verdict and end of run
   task automatic tally_and_finish();
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never matches
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for the next change of one count
   task automatic wait_step(input int i, input int bound);
      old = count_value[i];
      n = 0;
      while (count_value[i] === old) begin
         @(negedge sys_clk);
         n++;
         if (n > bound) begin
            miscompares++;
            tally_and_finish();
         end
      end
   endtask

   // One-cycle software load, highest priority
   task automatic load(input int i, input logic [15:0] v);
      load_value[i] = v;
      load_strobe[i] = 1'b1;
      @(negedge sys_clk);
      load_strobe[i] = 1'b0;
   endtask

   initial begin
      mode = '{default: timer_module_one_pkg::MODE_TIMER};
      edge_sel = '{default: timer_module_one_pkg::EDGE_RISE};
      aux_func = '{default: timer_module_one_pkg::AUX_COUNT};
      {run, count_down, dir_pin_enable, aux_src_latch, reload_from_latch} = 15'h0000;
      {load_strobe, irq_clear, presc_sel} = 15'h0000;
      gate_level = 3'h7;
      load_value = '0;
      toggle_out_enable = 1'b1;
      repeat (20) @(negedge sys_clk);
      check("reset count", 16'h0000, count_value[1]);
      check("reset latch", 16'h0000, 16'(core_toggle_latch));
      rst_n = 1'b1;
      run = 3'h1;
      // Ordinary cases: period and direction per select
      for (int r = 0; r < 8; r++) begin
         presc_sel[0] = rows[r].sel;
         count_down[0] = rows[r].down;
         wait_step(0, 2100);
         wait_step(0, 2100);
         check("period", 16'(rows[r].period), 16'(n));
         check("step", old + (rows[r].down ? 16'hffff : 16'h0001), count_value[0]);
      end
      // Core wraps both ways; aux_high counts latch flips
      run = 3'h6;
      mode[2] = timer_module_one_pkg::MODE_COUNTER;
      edge_sel[2] = timer_module_one_pkg::EDGE_BOTH;
      aux_src_latch[2] = 1'b1;
      load(2, 16'h0000);
      load(1, 16'hffff);
      wait_step(1, 20);
      check("wrap up", 16'h0000, count_value[1]);
      check("irq", 16'h0001, 16'(irq_flag[1]));
      check("latch", 16'h0001, 16'(core_toggle_latch));
      check("out pin", 16'h0001, 16'(toggle_output_pin));
      count_down[1] = 1'b1;
      wait_step(1, 20);
      check("wrap down", 16'hffff, count_value[1]);
      check("latch back", 16'h0000, 16'(core_toggle_latch));
      run[1] = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("latch clocked", 16'h0002, count_value[2]);
      irq_clear[1] = 1'b1;
      @(negedge sys_clk);
      irq_clear[1] = 1'b0;
      check("irq cleared", 16'h0000, 16'(irq_flag[1]));
      // Counter mode, then direction pin reverses it
      aux_src_latch[2] = 1'b0;
      edge_sel[2] = timer_module_one_pkg::EDGE_RISE;
      load(2, 16'h0000);
      repeat (3) src.pulse(2);
      check("events", 16'h0003, count_value[2]);
      dir_pin_enable[2] = 1'b1;
      src.dir_pin[2] = 1'b1;
      repeat (2) src.pulse(2);
      check("dir pin", 16'h0001, count_value[2]);
      // Encoder phases forward four, back six
      dir_pin_enable[2] = 1'b0;
      mode[2] = timer_module_one_pkg::MODE_INCREMENTAL;
      load(2, 16'h0010);
      repeat (4) src.quad(2, 1'b1);
      check("enc fwd", 16'h0014, count_value[2]);
      repeat (6) src.quad(2, 1'b0);
      check("enc back", 16'h000e, count_value[2]);
      // Gate closed holds, open counts
      mode[0] = timer_module_one_pkg::MODE_GATED;
      count_down[0] = 1'b0;
      presc_sel[0] = 3'h0;
      run[0] = 1'b1;
      load(0, 16'h0000);
      repeat (40) @(negedge sys_clk);
      check("gate shut", 16'h0000, count_value[0]);
      src.in_pin[0] = 1'b1;
      repeat (40) @(negedge sys_clk);
      check("gate open", 16'h0001, 16'(count_value[0] > 16'h0003));
      // Capture of a still core value; held aux does not count
      src.in_pin[0] = 1'b0;
      mode[0] = timer_module_one_pkg::MODE_TIMER;
      aux_func[0] = timer_module_one_pkg::AUX_CAPTURE;
      load(1, 16'h1234);
      load(0, 16'h0000);
      repeat (30) @(negedge sys_clk);
      check("aux held", 16'h0000, count_value[0]);
      src.pulse(0);
      check("capture", 16'h1234, count_value[0]);
      // Opposite latch edges reload alternately: pulse train
      aux_func[0] = timer_module_one_pkg::AUX_RELOAD;
      aux_func[2] = timer_module_one_pkg::AUX_RELOAD;
      edge_sel[2] = timer_module_one_pkg::EDGE_FALL;
      reload_from_latch = 3'h5;
      load(0, 16'hfffc);
      load(2, 16'hfffa);
      count_down[1] = 1'b0;
      run[1] = 1'b1;
      load(1, 16'hffff);
      repeat (2) wait_step(1, 20);
      check("reload low", 16'hfffc, count_value[1]);
      repeat (5) wait_step(1, 20);
      check("reload high", 16'hfffa, count_value[1]);
      repeat (7) wait_step(1, 20);
      check("reload again", 16'hfffc, count_value[1]);
      // Mid-run reset clears counts, flags, latch and pin at once
      rst_n = 1'b0;
      @(negedge sys_clk);
      check("reset counts", 16'h0000, count_value[0] | count_value[1] | count_value[2]);
      check("reset flags", 16'h0000, 16'({irq_flag, core_toggle_latch, toggle_output_pin}));
      rst_n = 1'b1;
      // Prescaler restarts from zero, so no step within two cycles
      repeat (2) @(negedge sys_clk);
      check("restart", 16'h0000, count_value[1]);
      tally_and_finish();
   end
endmodule
